// File: test/host.sv
// Host controller model driving select, serial clock and data lines
`timescale 1ns/1ns
module host (
    output logic chip_select_n, // Select, high between frames
    output logic serial_clock, // Idles high, still outside frames
    output logic [3:0] line_drive, // Host values on data lines
    input wire logic [3:0] line_level // Resolved data lines
);
    // Idle levels
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b1;
        line_drive = 4'h0;
    end
    // One serial clock: lines change on the fall, sampled at the rise
    task automatic tick(input logic [3:0] v, output logic [3:0] g);
        serial_clock = 1'b0;
        line_drive = v;
        #80 serial_clock = 1'b1;
        g = line_level;
        #80;
    endtask : tick
    // Units MSB first: nibbles when quad, else bits on line zero
    task automatic send(input logic [31:0] v, input int n, input bit quad);
        logic [3:0] g;
        for (int i = n - 1; i >= 0; i--) begin
            if (quad) tick(v[4*i+:4], g);
            else tick({3'($urandom), v[i]}, g);
        end
    endtask : send
    // Select edge with the clock held high; host line values inverted after a frame
    task automatic frame(input bit on);
        #80 chip_select_n = !on;
        if (!on) line_drive = ~line_drive;
        #80;
    endtask : frame
    // One read byte, high nibble first
    task automatic get(output logic [7:0] b);
        tick(4'($urandom), b[7:4]);
        tick(4'($urandom), b[3:0]);
    endtask : get
endmodule : host

// File: test/tb.sv
// Self-checking bench for the quad read, wrap and page program sequencer
`timescale 1ns/1ns
module tb import qflash_pkg::*;;
    localparam int PROG_N = 300;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic quad_enable_bit;
    logic [4:0] block_guard_bits;
    logic chip_select_n, serial_clock, write_latch_flag, write_progress_flag, cont_flag;
    logic [3:0] line_drive, line_level, dev_out, dev_oe;
    logic [2:0] wrap_setting_bits;
    logic [7:0] mem [int];
    logic [7:0] exp_q [$];
    logic [7:0] seen, want;
    string what;
    int failures = 0, cmp_count = 0, cycles = 0;
    event got;
    // Wire level from the device enables, host values elsewhere
    assign line_level = (dev_oe & dev_out) | (~dev_oe & line_drive);
    qflash_seq #(.PROG_CYCLES(PROG_N)) qflash_seq_inst (.clk(clk), .reset_n(reset_n),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .quad_line_zero_in(line_level[0]), .quad_line_one_in(line_level[1]),
        .quad_line_two_in(line_level[2]), .quad_line_three_in(line_level[3]),
        .quad_line_zero_out(dev_out[0]), .quad_line_one_out(dev_out[1]),
        .quad_line_two_out(dev_out[2]), .quad_line_three_out(dev_out[3]),
        .quad_line_zero_oe(dev_oe[0]), .quad_line_one_oe(dev_oe[1]),
        .quad_line_two_oe(dev_oe[2]), .quad_line_three_oe(dev_oe[3]),
        .quad_enable_bit(quad_enable_bit), .block_guard_bits(block_guard_bits),
        .write_latch_flag(write_latch_flag), .write_progress_flag(write_progress_flag),
        .wrap_setting_bits(wrap_setting_bits), .continuous_mode_active(cont_flag));
    host host_inst (.chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .line_drive(line_drive), .line_level(line_level));
    // Clock and run limit
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            results();
        end
    end
    // Oldest note against what was seen
    always @(got) begin
        want = exp_q.pop_front();
        cmp_count++;
        if (want !== seen) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    end
    task automatic note(input string n, input logic [7:0] e, input logic [7:0] s);
        exp_q.push_back(e);
        what = n;
        seen = s;
        -> got;
        #1;
    endtask : note
    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wclk
    task automatic unlock();
        host_inst.frame(1'b1);
        host_inst.send(OP_UNLOCK, 8, 1'b0);
        host_inst.frame(1'b0);
        note("latch", 8'h01, {7'h0, write_latch_flag});
    endtask : unlock
    // Program frame: n bytes, then stray bits; ok says a cycle must start
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
                        input int extra, input bit ok, input bit lat);
        logic [7:0] b;
        host_inst.frame(1'b1);
        host_inst.send(op, 8, 1'b0);
        host_inst.send(a, 24, 1'b0);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            host_inst.send(b, op == OP_QUAD_WRITE ? 2 : 8, op == OP_QUAD_WRITE);
            if (ok) mem[int'({a[23:8], 8'(a[7:0] + i)})] = b;
        end
        host_inst.send(0, extra, 1'b0);
        host_inst.frame(1'b0);
        wclk(20);
        note("busy", {7'h0, ok}, {7'h0, write_progress_flag});
        note("latch", {7'h0, lat}, {7'h0, write_latch_flag});
        for (int i = 0; i < PROG_N + 20 && write_progress_flag === 1'b1; i++) wclk(1);
        note("idle", 8'h00, {7'h0, write_progress_flag});
    endtask : prog
    task automatic wrap(input logic [7:0] w);
        host_inst.frame(1'b1);
        host_inst.send(OP_WRAP_SET, 8, 1'b0);
        host_inst.send(0, 24, 1'b0);
        host_inst.send(w, 8, 1'b0);
        host_inst.frame(1'b0);
        note("wrap", {5'h0, w[6:4]}, {5'h0, wrap_setting_bits});
    endtask : wrap
    // Word read of n bytes; mask limits the address to its section
    task automatic rd(input bit cont, input logic [23:0] a, input logic [7:0] m, input int n,
                      input int mask);
        logic [7:0] b;
        host_inst.frame(1'b1);
        if (!cont) host_inst.send(OP_WORD_READ, 8, 1'b0);
        host_inst.send(a, 6, 1'b1);
        host_inst.send(m, 2, 1'b1);
        host_inst.send(0, 2, 1'b1);
        for (int i = 0; i < n; i++) begin
            host_inst.get(b);
            note("read", mem[(int'(a) & ~mask) | ((int'(a) + i) & mask)], b);
        end
        host_inst.frame(1'b0);
    endtask : rd
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // Main sequence
    initial begin
        seen = 8'($urandom(63));
        quad_enable_bit = 1'b1;
        block_guard_bits = 5'h00;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        wclk(3);
        note("wrap", 8'h01, {5'h0, wrap_setting_bits});
        prog(OP_PAGE_WRITE, 24'h00_0200, 1, 0, 1'b0, 1'b0);
        unlock();
        block_guard_bits = 5'($urandom_range(31, 1));
        prog(OP_PAGE_WRITE, 24'h00_0200, 2, 0, 1'b0, 1'b1);
        block_guard_bits = 5'h00;
        prog(OP_PAGE_WRITE, 24'h00_0200, 1, 4, 1'b0, 1'b1);
        prog(OP_PAGE_WRITE, 24'h00_00FE, 66, 0, 1'b1, 1'b0);
        unlock();
        quad_enable_bit = 1'b0;
        prog(OP_QUAD_WRITE, 24'h00_0100, 2, 0, 1'b0, 1'b1);
        quad_enable_bit = 1'b1;
        block_guard_bits = 5'($urandom_range(31, 1));
        prog(OP_QUAD_WRITE, 24'h00_0100, 1, 0, 1'b0, 1'b1);
        block_guard_bits = 5'h00;
        prog(OP_QUAD_WRITE, 24'h00_0100, 2, 0, 1'b1, 1'b0);
        unlock();
        prog(OP_QUAD_WRITE, 24'h00_0200, 258, 0, 1'b1, 1'b0);
        $display("test program done");
        for (int k = 0; k < 4; k++) begin
            wrap(8'(k << 5));
            rd(1'b0, 24'(8 << k) - 24'h00_0002, 8'h00, 4, (8 << k) - 1);
        end
        wrap(8'h10);
        rd(1'b0, 24'h00_0200, 8'h00, 4, -1);
        rd(1'b0, 24'h00_00FE, 8'h20, 4, -1);
        note("cont", 8'h01, {7'h0, cont_flag});
        rd(1'b1, 24'h00_00FE, 8'h00, 4, -1);
        note("cont", 8'h00, {7'h0, cont_flag});
        quad_enable_bit = 1'b0;
        rd(1'b0, 24'h00_00FE, 8'h20, 0, -1);
        note("cont", 8'h00, {7'h0, cont_flag});
        $display("test read done");
        results();
    end
endmodule : tb

// File: verilog/page_store.sv
// Memory array, page buffer and self-timed program engine
`timescale 1ns/1ns
module page_store import qflash_pkg::*; #(
    parameter int MEM_AW = 12,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic [23:0] rd_addr, // Read byte address
    output logic [7:0] rd_data, // Read byte
    input wire logic buf_clear, // Empty the page buffer
    input wire logic buf_wr, // Store one buffer byte
    input wire logic [7:0] buf_col, // Column within the page
    input wire logic [7:0] buf_data, // Byte to store
    input wire logic prog_start, // Start the timed cycle
    input wire logic [15:0] prog_page, // Page to program
    output logic busy // Cycle running
);
    localparam int CW = $clog2(PROG_CYCLES + 1);
    logic [7:0] mem [2**MEM_AW];
    logic [7:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [15:0] page_q;
    logic [CW-1:0] cnt_q;
    logic busy_q;

    if (PROG_CYCLES <= PAGE_BYTES || MEM_AW < 8 || MEM_AW > 24) begin : g_bad_cfg
        $error("page_store needs more cycles than page bytes and 8..24 address bits");
    end

    // ==================================================
    // Decoding of the commit walk
    wire [7:0] col = cnt_q[7:0];
    wire commit = busy_q && (cnt_q < CW'(PAGE_BYTES)) && mask_q[col];
    wire [MEM_AW-1:0] wr_idx = MEM_AW'({page_q, col});
    assign rd_data = mem[MEM_AW'(rd_addr)];
    assign busy = busy_q;

    // Later bytes at a column overwrite earlier ones
    always_ff @(posedge clk) begin
        if (buf_wr) begin
            pbuf[buf_col] <= buf_data;
        end
    end

    // Marks the columns that were sent
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= '0;
        end else if (buf_clear) begin
            mask_q <= '0;
        end else if (buf_wr) begin
            mask_q[buf_col] <= 1'b1;
        end
    end

    // Self-timed cycle counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            page_q <= '0;
        end else if (prog_start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= CW'(PROG_CYCLES - 1);
            page_q <= prog_page;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    // Only marked columns reach the array
    always_ff @(posedge clk) begin
        if (commit) begin
            mem[wr_idx] <= pbuf[col];
        end
    end

    AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(busy_q) |-> busy_q[*8]) else $error("busy cycle ended too soon");
    AST_BUSY_END: assert property (@(posedge clk) disable iff (!reset_n)
        busy_q && cnt_q == '0 |=> !busy_q) else $error("busy did not end");
endmodule : page_store

// File: verilog/pin_sync.sv
// Two-flop pin synchroniser with edge pulses
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic [WIDTH-1:0] async_in, // Pins from outside
    output logic [WIDTH-1:0] level, // Synchronised level
    output logic [WIDTH-1:0] rise, // One-cycle rising pulse
    output logic [WIDTH-1:0] fall // One-cycle falling pulse
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be positive");
    end

    // ==================================================
    // Two flops, then a delay stage that only edges read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
            prev_q <= RESET_VALUE;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge pulses from the settled stages only
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule : pin_sync

// File: verilog/qflash_pkg.sv
// Constants, codes and states for the quad read, wrap and page program sequencer
// Function
// - Word read: even address, two dummy clocks
// - Quad read: address, mode, four dummies
// - Read address steps up after each byte
// - Quad reads need the quad enable bit
// - Mode bits 10 skip next opcode
// - Other mode bits restore opcode decoding
// - Wrap keeps reads inside aligned section
// - Bit four low wraps; bits six-five length
// - Wrap setting holds until rewritten
// - Data past page end wraps in page
// - Over 256 bytes keeps the last 256
// - Unsent page bytes stay unchanged
// - Select must rise on byte boundary
// - Select rise starts timed busy cycle
// - Write latch clears before cycle ends
// - Guarded page blocks single-line program
// - Quad program needs quad enable, latch
// - Quad program dropped on partial byte
// - Guarded page blocks quad program
// - Quad data high nibble first
// - Reads during busy cycle are rejected
package qflash_pkg;
    // ==================================================
    // Command codes
    localparam logic [7:0] OP_UNLOCK = 8'h06;
    localparam logic [7:0] OP_STATUS = 8'h05;
    localparam logic [7:0] OP_WORD_READ = 8'hE7;
    localparam logic [7:0] OP_QUAD_READ = 8'hEB;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_QUAD_WRITE = 8'h32;
    // ==================================================
    // Field lengths as last edge index
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [5:0] QADDR_LAST = 6'h05;
    localparam logic [5:0] MODE_LAST = 6'h01;
    localparam logic [5:0] WORD_DUMMY_LAST = 6'h01;
    localparam logic [5:0] QUAD_DUMMY_LAST = 6'h03;
    localparam logic [5:0] WRAP_LAST = 6'h1F;
    localparam logic [5:0] SADDR_LAST = 6'h17;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // ==================================================
    // Field values and masks
    localparam logic [1:0] CONT_KEEP = 2'h2;
    localparam logic [2:0] WRAP_RESET = 3'h1;
    localparam logic [23:0] SECTION_MIN = 24'h00_0008;
    localparam logic [23:0] PAGE_MASK = 24'h00_00FF;
    localparam logic [23:0] FULL_MASK = 24'hFF_FFFF;
    localparam logic [23:0] ADDR_STEP = 24'h00_0001;
    localparam int PAGE_BYTES = 256;
    // ==================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 50000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    // ==================================================
    // Sequencer states
    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_OPCODE = 11'h002,
        ST_QADDR = 11'h004,
        ST_MODE = 11'h008,
        ST_DUMMY = 11'h010,
        ST_RDATA = 11'h020,
        ST_STAT = 11'h040,
        ST_WRAP = 11'h080,
        ST_PADDR = 11'h100,
        ST_PDATA = 11'h200,
        ST_IGNORE = 11'h400
    } seq_state_type;
endpackage : qflash_pkg

// File: verilog/qflash_seq.sv
// Serial flash sequencer for quad reads, wrap setting and page programs
`timescale 1ns/1ns
module qflash_seq import qflash_pkg::*; #(
    parameter int MEM_AW = 12,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic chip_select_n, // Select pin from host
    input wire logic serial_clock, // Serial clock pin
    input wire logic quad_line_zero_in, // Data line 0 in
    input wire logic quad_line_one_in, // Data line 1 in
    input wire logic quad_line_two_in, // Data line 2 in
    input wire logic quad_line_three_in, // Data line 3 in
    output logic quad_line_zero_out, // Data line 0 out
    output logic quad_line_one_out, // Data line 1 out
    output logic quad_line_two_out, // Data line 2 out
    output logic quad_line_three_out, // Data line 3 out
    output logic quad_line_zero_oe, // Data line 0 driven
    output logic quad_line_one_oe, // Data line 1 driven
    output logic quad_line_two_oe, // Data line 2 driven
    output logic quad_line_three_oe, // Data line 3 driven
    input wire logic quad_enable_bit, // Quad commands allowed
    input wire logic [4:0] block_guard_bits, // Nonzero guards pages
    output logic write_latch_flag, // Write latch state
    output logic write_progress_flag, // Program cycle running
    output logic [2:0] wrap_setting_bits, // Stored wrap bits
    output logic continuous_mode_active // Opcode skipped next
);
    seq_state_type st_q;
    logic [5:0] cnt_q;
    logic [7:0] op_q;
    logic [7:0] byte_q;
    logic [23:0] addr_q;
    logic [3:0] out_q;
    logic [3:0] oe_q;
    logic [2:0] wrap_q;
    logic word_q;
    logic cont_q;
    logic cont_word_q;
    logic prog_quad_q;
    logic wel_q;
    logic any_q;
    logic nib_hi_q;
    logic buf_clear_q;
    logic buf_wr_q;
    logic start_q;
    logic busy;
    logic [7:0] rd_data;
    logic [5:0] s_lvl;
    logic [5:0] s_rise;
    logic [5:0] s_fall;

    if (MEM_AW < 8 || MEM_AW > 24) begin : g_bad_aw
        $error("qflash_seq address width must be 8..24");
    end

    // Address step that stays within the masked section
    function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [23:0] m);
        next_addr = (a & ~m) | ((a + ADDR_STEP) & m);
    endfunction : next_addr

    // ==================================================
    // Pin sampling
    pin_sync #(.WIDTH(6), .RESET_VALUE(6'h03)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({quad_line_three_in, quad_line_two_in, quad_line_one_in,
                   quad_line_zero_in, serial_clock, chip_select_n}),
        .level(s_lvl),
        .rise(s_rise),
        .fall(s_fall)
    );

    // ==================================================
    // Storage and timed program engine
    page_store #(.MEM_AW(MEM_AW), .PROG_CYCLES(PROG_CYCLES)) u_store (
        .clk(clk),
        .reset_n(reset_n),
        .rd_addr(addr_q),
        .rd_data(rd_data),
        .buf_clear(buf_clear_q),
        .buf_wr(buf_wr_q),
        .buf_col(addr_q[7:0]),
        .buf_data(byte_q),
        .prog_start(start_q),
        .prog_page(addr_q[23:8]),
        .busy(busy)
    );

    // ==================================================
    // Decoding
    wire cs_rise = s_rise[0];
    wire cs_fall = s_fall[0];
    wire sck_rise = s_rise[1];
    wire sck_fall = s_fall[1];
    wire si = s_lvl[2];
    wire [3:0] din = s_lvl[5:2];
    wire [7:0] op_next = {op_q[6:0], si};
    wire [7:0] sbyte_next = {byte_q[6:0], si};
    wire [7:0] qbyte_next = {byte_q[3:0], din};
    wire [7:0] pbyte_next = prog_quad_q ? qbyte_next : sbyte_next;
    wire byte_done = prog_quad_q ? cnt_q[0] : (cnt_q[2:0] == BIT_LAST);
    wire wrap_on = !wrap_q[0];
    wire [23:0] sec_mask = (SECTION_MIN << wrap_q[2:1]) - ADDR_STEP;
    wire [23:0] rd_mask = wrap_on ? sec_mask : FULL_MASK;
    wire [5:0] dummy_last = word_q ? WORD_DUMMY_LAST : QUAD_DUMMY_LAST;
    wire [7:0] status = {6'h00, wel_q, busy};
    wire is_read = (op_next == OP_WORD_READ) || (op_next == OP_QUAD_READ);
    wire is_prog = (op_next == OP_PAGE_WRITE) || (op_next == OP_QUAD_WRITE);
    wire read_ok = quad_enable_bit && !busy;
    wire prog_ok = wel_q && !busy && (op_next != OP_QUAD_WRITE || quad_enable_bit);
    wire guard_hit = block_guard_bits != 5'h00;
    wire prog_go = st_q == ST_PDATA && cnt_q == 6'h00 && any_q && !guard_hit;
    seq_state_type op_state;
    assign op_state = is_read ? (read_ok ? ST_QADDR : ST_IGNORE)
                    : is_prog ? (prog_ok ? ST_PADDR : ST_IGNORE)
                    : (op_next == OP_WRAP_SET) ? ST_WRAP
                    : (op_next == OP_STATUS) ? ST_STAT : ST_IGNORE;

    // Outputs straight from flops
    assign {quad_line_three_out, quad_line_two_out, quad_line_one_out, quad_line_zero_out} = out_q;
    assign {quad_line_three_oe, quad_line_two_oe, quad_line_one_oe, quad_line_zero_oe} = oe_q;
    assign write_latch_flag = wel_q;
    assign write_progress_flag = busy;
    assign wrap_setting_bits = wrap_q;
    assign continuous_mode_active = cont_q;

    // ==================================================
    // Frame sequencer: samples on clock rise, drives on clock fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            op_q <= '0;
            byte_q <= '0;
            addr_q <= '0;
            out_q <= '0;
            oe_q <= '0;
            wrap_q <= WRAP_RESET;
            word_q <= 1'b0;
            cont_q <= 1'b0;
            cont_word_q <= 1'b0;
            prog_quad_q <= 1'b0;
            wel_q <= 1'b0;
            any_q <= 1'b0;
            nib_hi_q <= 1'b1;
            buf_clear_q <= 1'b0;
            buf_wr_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            buf_clear_q <= 1'b0;
            buf_wr_q <= 1'b0;
            start_q <= 1'b0;
            if (cs_rise) begin
                if (prog_go) begin
                    start_q <= 1'b1;
                    wel_q <= 1'b0;
                end
                st_q <= ST_IDLE;
                oe_q <= '0;
            end else if (cs_fall) begin
                cnt_q <= '0;
                word_q <= cont_word_q;
                st_q <= !cont_q ? ST_OPCODE : read_ok ? ST_QADDR : ST_IGNORE;
            end else if (sck_rise) begin
                cnt_q <= cnt_q + 6'h01;
                case (st_q)
                    ST_OPCODE: begin
                        op_q <= op_next;
                        if (cnt_q == OPCODE_LAST) begin
                            cnt_q <= '0;
                            st_q <= op_state;
                            word_q <= op_next == OP_WORD_READ;
                            prog_quad_q <= op_next == OP_QUAD_WRITE;
                            // Only an accepted program clears the marks, and it needs busy low, so a running commit keeps them
                            buf_clear_q <= op_state == ST_PADDR;
                            any_q <= 1'b0;
                            if (op_next == OP_UNLOCK && !busy) begin
                                wel_q <= 1'b1;
                            end
                        end
                    end
                    ST_QADDR: begin
                        addr_q <= {addr_q[19:0], din};
                        if (cnt_q == QADDR_LAST) begin
                            cnt_q <= '0;
                            st_q <= ST_MODE;
                        end
                    end
                    ST_MODE: begin
                        byte_q <= qbyte_next;
                        if (cnt_q == MODE_LAST) begin
                            cnt_q <= '0;
                            cont_q <= qbyte_next[5:4] == CONT_KEEP;
                            cont_word_q <= word_q;
                            st_q <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        if (cnt_q == dummy_last) begin
                            st_q <= ST_RDATA;
                            nib_hi_q <= 1'b1;
                        end
                    end
                    ST_STAT: begin
                        cnt_q <= cnt_q;
                    end
                    ST_WRAP: begin
                        byte_q <= sbyte_next;
                        if (cnt_q == WRAP_LAST) begin
                            wrap_q <= sbyte_next[6:4];
                            st_q <= ST_IGNORE;
                        end
                    end
                    ST_PADDR: begin
                        addr_q <= {addr_q[22:0], si};
                        if (cnt_q == SADDR_LAST) begin
                            cnt_q <= '0;
                            st_q <= ST_PDATA;
                        end
                    end
                    ST_PDATA: begin
                        byte_q <= pbyte_next;
                        if (byte_done) begin
                            cnt_q <= '0;
                            buf_wr_q <= 1'b1;
                            any_q <= 1'b1;
                        end
                    end
                    default: begin
                        cnt_q <= '0;
                    end
                endcase
            end else if (sck_fall) begin
                case (st_q)
                    ST_RDATA: begin
                        oe_q <= 4'hF;
                        out_q <= nib_hi_q ? rd_data[7:4] : rd_data[3:0];
                        nib_hi_q <= !nib_hi_q;
                        if (!nib_hi_q) begin
                            addr_q <= next_addr(addr_q, rd_mask);
                        end
                    end
                    ST_STAT: begin
                        oe_q <= 4'h2;
                        out_q <= {2'h0, status[BIT_LAST - cnt_q[2:0]], 1'b0};
                        cnt_q <= cnt_q + 6'h01;
                    end
                    default: begin
                        oe_q <= oe_q;
                    end
                endcase
            end else if (buf_wr_q) begin
                addr_q <= next_addr(addr_q, PAGE_MASK);
            end
        end
    end

    // ==================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire quiet = !cs_rise && !cs_fall;
    sequence s_good_end;
        cs_rise && prog_go;
    endsequence
    sequence s_busy_start;
        start_q && !wel_q ##1 write_progress_flag ##1 write_progress_flag;
    endsequence

    AST_DUMMY_COUNT: assert property (
        st_q == ST_DUMMY && sck_rise && quiet && cnt_q == (word_q ? 6'h01 : 6'h03)
        |=> st_q == ST_RDATA) else $error("wrong dummy clock count");
    AST_READ_STEP: assert property (
        st_q == ST_RDATA && sck_fall && quiet && !nib_hi_q && !wrap_on
        |=> addr_q == $past(addr_q) + ADDR_STEP) else $error("read address not stepped");
    AST_QE_GATE: assert property (
        st_q == ST_OPCODE && sck_rise && quiet && cnt_q == OPCODE_LAST && is_read
        && !quad_enable_bit |=> st_q == ST_IGNORE) else $error("quad read without enable");
    AST_CONT_SKIP: assert property (
        cs_fall && cont_q && read_ok |=> st_q == ST_QADDR) else $error("opcode not skipped");
    AST_CONT_END: assert property (
        st_q == ST_MODE && sck_rise && quiet && cnt_q == MODE_LAST
        && qbyte_next[5:4] != CONT_KEEP |=> !cont_q) else $error("continuous mode kept");
    AST_WRAP_STAY: assert property (
        st_q == ST_RDATA && sck_fall && quiet && !nib_hi_q && wrap_on
        |=> (addr_q & ~$past(rd_mask)) == ($past(addr_q) & ~$past(rd_mask)))
        else $error("read left the wrap section");
    AST_WRAP_STORE: assert property (
        st_q == ST_WRAP && sck_rise && quiet && cnt_q == WRAP_LAST
        |=> wrap_q == $past(sbyte_next[6:4])) else $error("wrap bits not stored");
    AST_PAGE_STAY: assert property (
        buf_wr_q |=> addr_q[23:8] == $past(addr_q[23:8])) else $error("program left the page");
    AST_PROG_START: assert property (
        s_good_end |=> s_busy_start) else $error("program cycle did not start");
    AST_PARTIAL_DROP: assert property (
        cs_rise && st_q == ST_PDATA && cnt_q != 6'h00 |=> !start_q)
        else $error("partial byte program started");
    AST_GUARD_DROP: assert property (
        cs_rise && guard_hit |=> !start_q) else $error("guarded page programmed");
    AST_NO_LATCH: assert property (
        st_q == ST_OPCODE && sck_rise && quiet && cnt_q == OPCODE_LAST && is_prog && !wel_q
        |=> st_q == ST_IGNORE) else $error("program accepted without write latch");
    AST_BUSY_READ: assert property (
        cs_fall && cont_q && busy |=> st_q == ST_IGNORE) else $error("read accepted while busy");
endmodule : qflash_seq
